// *** hdl/wdtrc_params.svh ***
// offsets, field positions, reset values and timing counts of the watchdog reset controller
`ifndef WDTRC_PARAMS_SVH
`define WDTRC_PARAMS_SVH
`define WDTRC_AW 3
`define WDTRC_OFS_CTRL 3'h0
`define WDTRC_OFS_FLAGS 3'h1
`define WDTRC_OFS_PWR 3'h2
`define WDTRC_OFS_ISTAT 3'h3
`define WDTRC_OFS_IEN 3'h4
`define WDTRC_OFS_ICLR 3'h5
`define WDTRC_OFS_PDATA 3'h6
`define WDTRC_OFS_PDIR 3'h7
`define WDTRC_EN_MSB 7
`define WDTRC_EN_LSB 3
`define WDTRC_PS_MSB 2
`define WDTRC_PS_LSB 0
`define WDTRC_CODE_EN 5'h0A
`define WDTRC_CODE_DIS 5'h15
`define WDTRC_CTRL_POR 8'h53
`define WDTRC_PORT_POR 8'hFF
`define WDTRC_FLAG_WRF 0
`define WDTRC_PWR_TO 0
`define WDTRC_PWR_PDF 1
`define WDTRC_EV_TMO 0
`define WDTRC_EV_SRST 1
`define WDTRC_CNT_W 18
`define WDTRC_CLK_NS 25
`define WDTRC_SRESET_NS 100000
`define WDTRC_SRESET_CYC ((`WDTRC_SRESET_NS + `WDTRC_CLK_NS - 1) / `WDTRC_CLK_NS)
`endif

// *** hdl/wdtrc_pkg.sv ***
// types shared by the watchdog reset controller
`default_nettype none
package wdtrc_pkg;
    // register port request from the cpu side
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdtrc_req_t;
    // instruction and mode events from the cpu core
    typedef struct packed {
        logic clear_watchdog_instruction;
        logic halt;
        logic sleep;
    } wdtrc_cpu_t;
    // watchdog state, one-hot
    typedef enum logic [2:0] {
        WDTRC_ST_RUN = 3'b001,
        WDTRC_ST_OFF = 3'b010,
        WDTRC_ST_PEND = 3'b100
    } wdtrc_state_t;
endpackage : wdtrc_pkg
`default_nettype wire

// *** hdl/wdtrc_top.sv ***
// watchdog timer with code-checked enable, reset cause flags and reset outputs
//
// The address map and the strobed register port are this design's own decisions.
`include "wdtrc_params.svh"
`default_nettype none
// Summary of operation
// - counter advances only on low-speed clock ticks
// - period select picks 2^8 to 2^18
// - enable code lets watchdog count, time out
// - disable code stops watchdog, no time-out
// - illegal code: full reset after fixed delay
// - illegal-code reset sets soft reset flag
// - flag set by hardware, software only clears
// - power-on loads enable code, period 011
// - normal overflow: full reset, time-out flag
// - sleep overflow: flag, clear pc and sp
// - illegal code, clear instruction, halt clear count
// - flag register bits 7..4 read zero
// - program counter zero after power-on
// - port data and direction power up ones
// - halt clears count, resumes if enabled
// - sleep time-out leaves both flags one
module wdtrc_top #(
    parameter int SRESET_CYC = `WDTRC_SRESET_CYC
) (
    input wire logic clk_i, // 40 MHz system clock
    input wire logic arst_n_i, // power-on reset, async, active low
    input wire logic low_speed_rc_oscillator_tick_i, // one-cycle pulse per low-speed clock period
    input wire wdtrc_pkg::wdtrc_req_t bus_i, // register port request
    input wire wdtrc_pkg::wdtrc_cpu_t cpu_i, // cpu instruction and mode events
    output logic [7:0] rdata_o, // read data, cycle after read strobe
    output logic dev_reset_o, // full device reset pulse
    output logic pc_sp_clear_o, // clear program counter and stack pointer
    output logic [7:0] port_data_o, // port data register
    output logic [7:0] port_dir_o, // port direction register, one is input
    output logic irq_o // level interrupt
);
    import wdtrc_pkg::*;

    localparam int CW = `WDTRC_CNT_W;
    localparam logic [12:0] DLY_LAST = 13'(SRESET_CYC - 1);

    // last count value of each period, the counter wraps at the chosen power of two
    function automatic logic [CW-1:0] period_last(input logic [2:0] ps);
        logic [4:0] e;
        e = 5'h08;
        case (ps)
            3'h0: e = 5'h08;
            3'h1: e = 5'h0A;
            3'h2: e = 5'h0C;
            3'h3: e = 5'h0E;
            3'h4: e = 5'h0F;
            3'h5: e = 5'h10;
            3'h6: e = 5'h11;
            default: e = 5'h12;
        endcase
        return CW'((19'h00001 << e) - 19'h00001);
    endfunction : period_last

    wdtrc_state_t st_r, st_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [12:0] dly_r, dly_nxt;
    logic wrf_r, wrf_nxt;
    logic to_r, to_nxt;
    logic pdf_r, pdf_nxt;
    logic [1:0] ist_r, ist_nxt;
    logic [1:0] ien_r, ien_nxt;
    logic [7:0] pdata_r, pdata_nxt;
    logic [7:0] pdir_r, pdir_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic devrst_r, devrst_nxt;
    logic pcsp_r, pcsp_nxt;
    logic tmo;
    logic srst_fire;
    logic full_rst;
    logic [4:0] code;

    // write decode strobes
    logic wr_ctrl, wr_flags, wr_ien, wr_iclr, wr_pdata, wr_pdir;
    always_comb begin
        wr_ctrl = 1'b0;
        wr_flags = 1'b0;
        wr_ien = 1'b0;
        wr_iclr = 1'b0;
        wr_pdata = 1'b0;
        wr_pdir = 1'b0;
        if (bus_i.wr && bus_i.addr == `WDTRC_OFS_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (bus_i.wr && bus_i.addr == `WDTRC_OFS_FLAGS) begin
            wr_flags = 1'b1;
        end else if (bus_i.wr && bus_i.addr == `WDTRC_OFS_IEN) begin
            wr_ien = 1'b1;
        end else if (bus_i.wr && bus_i.addr == `WDTRC_OFS_ICLR) begin
            wr_iclr = 1'b1;
        end else if (bus_i.wr && bus_i.addr == `WDTRC_OFS_PDATA) begin
            wr_pdata = 1'b1;
        end else if (bus_i.wr && bus_i.addr == `WDTRC_OFS_PDIR) begin
            wr_pdir = 1'b1;
        end
    end

    // overflow: a tick lands on the last count while running and no clear or halt arrives with it
    // compared with >= so that shortening the period below the current count does not push overflow out to a wrap
    assign tmo = (st_r == WDTRC_ST_RUN) && low_speed_rc_oscillator_tick_i && (cnt_r >= period_last(ctrl_r[`WDTRC_PS_MSB:`WDTRC_PS_LSB]))
        && !cpu_i.clear_watchdog_instruction && !cpu_i.halt;
    // the delayed soft reset fires when its countdown is spent
    assign srst_fire = (st_r == WDTRC_ST_PEND) && (dly_r == 13'h0000);
    // a normal-mode overflow and the soft reset both reset the whole device
    assign full_rst = srst_fire || (tmo && !cpu_i.sleep);

    // control register, state and counter
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (full_rst) begin
            ctrl_nxt = `WDTRC_CTRL_POR;
        end else if (wr_ctrl) begin
            ctrl_nxt = bus_i.wdata;
        end
        code = ctrl_nxt[`WDTRC_EN_MSB:`WDTRC_EN_LSB];
        st_nxt = st_r;
        dly_nxt = dly_r;
        case (st_r)
            WDTRC_ST_PEND: begin
                // a pending noise reset cannot be called off by a later legal write
                if (full_rst) begin
                    st_nxt = WDTRC_ST_RUN;
                end else begin
                    dly_nxt = dly_r - 13'h0001;
                end
            end
            default: begin
                if (code == `WDTRC_CODE_EN) begin
                    st_nxt = WDTRC_ST_RUN;
                end else if (code == `WDTRC_CODE_DIS) begin
                    st_nxt = WDTRC_ST_OFF;
                end else begin
                    st_nxt = WDTRC_ST_PEND;
                    dly_nxt = DLY_LAST;
                end
            end
        endcase
        cnt_nxt = cnt_r;
        if (st_nxt != WDTRC_ST_RUN || st_r != WDTRC_ST_RUN || cpu_i.clear_watchdog_instruction || cpu_i.halt || tmo) begin
            cnt_nxt = '0;
        end else if (low_speed_rc_oscillator_tick_i) begin
            cnt_nxt = cnt_r + 18'h00001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= WDTRC_ST_RUN;
            ctrl_r <= `WDTRC_CTRL_POR;
            cnt_r <= '0;
            dly_r <= 13'h0000;
        end else begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            dly_r <= dly_nxt;
        end
    end

    // reset cause and power flags; hardware set wins over any clear in the same cycle
    always_comb begin
        wrf_nxt = wrf_r;
        if (wr_flags && !bus_i.wdata[`WDTRC_FLAG_WRF]) begin
            wrf_nxt = 1'b0;
        end
        if (srst_fire) begin
            wrf_nxt = 1'b1;
        end
        to_nxt = to_r;
        pdf_nxt = pdf_r;
        if (cpu_i.clear_watchdog_instruction) begin
            to_nxt = 1'b0;
            pdf_nxt = 1'b0;
        end
        if (cpu_i.halt) begin
            to_nxt = 1'b0;
            pdf_nxt = 1'b1;
        end
        if (tmo) begin
            to_nxt = 1'b1;
            if (cpu_i.sleep) begin
                pdf_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wrf_r <= 1'b0;
            to_r <= 1'b0;
            pdf_r <= 1'b0;
        end else begin
            wrf_r <= wrf_nxt;
            to_r <= to_nxt;
            pdf_r <= pdf_nxt;
        end
    end

    // reset outputs; pc and sp clear stands during power-on reset and one cycle after
    always_comb begin
        devrst_nxt = full_rst;
        pcsp_nxt = tmo && cpu_i.sleep;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            devrst_r <= 1'b0;
            pcsp_r <= 1'b1;
        end else begin
            devrst_r <= devrst_nxt;
            pcsp_r <= pcsp_nxt;
        end
    end

    // interrupt status, enable and port registers
    always_comb begin
        ist_nxt = ist_r;
        if (wr_iclr) begin
            ist_nxt = ist_r & ~bus_i.wdata[1:0];
        end
        if (tmo) begin
            ist_nxt[`WDTRC_EV_TMO] = 1'b1;
        end
        if (srst_fire) begin
            ist_nxt[`WDTRC_EV_SRST] = 1'b1;
        end
        ien_nxt = wr_ien ? bus_i.wdata[1:0] : ien_r;
        pdata_nxt = wr_pdata ? bus_i.wdata : pdata_r;
        pdir_nxt = wr_pdir ? bus_i.wdata : pdir_r;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ist_r <= 2'h0;
            ien_r <= 2'h0;
            pdata_r <= `WDTRC_PORT_POR;
            pdir_r <= `WDTRC_PORT_POR;
        end else begin
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            pdata_r <= pdata_nxt;
            pdir_r <= pdir_nxt;
        end
    end

    // read mux; write-only clear register and unused bits read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (!bus_i.rd) begin
            rdata_nxt = 8'h00;
        end else if (bus_i.addr == `WDTRC_OFS_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (bus_i.addr == `WDTRC_OFS_FLAGS) begin
            rdata_nxt = {7'h00, wrf_r};
        end else if (bus_i.addr == `WDTRC_OFS_PWR) begin
            rdata_nxt = {6'h00, pdf_r, to_r};
        end else if (bus_i.addr == `WDTRC_OFS_ISTAT) begin
            rdata_nxt = {6'h00, ist_r};
        end else if (bus_i.addr == `WDTRC_OFS_IEN) begin
            rdata_nxt = {6'h00, ien_r};
        end else if (bus_i.addr == `WDTRC_OFS_PDATA) begin
            rdata_nxt = pdata_r;
        end else if (bus_i.addr == `WDTRC_OFS_PDIR) begin
            rdata_nxt = pdir_r;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign dev_reset_o = devrst_r;
    assign pc_sp_clear_o = pcsp_r;
    assign port_data_o = pdata_r;
    assign port_dir_o = pdir_r;
    assign irq_o = |(ist_r & ien_r);

    // checks on the behaviour above
    a_tick_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!low_speed_rc_oscillator_tick_i && cnt_r != '0) |=> (cnt_r == $past(cnt_r) || cnt_r == '0))
        else $error("watchdog count moved without a low-speed tick");

    a_period_ovf: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_r == WDTRC_ST_RUN && low_speed_rc_oscillator_tick_i && !cpu_i.clear_watchdog_instruction && !cpu_i.halt
         && cnt_r == period_last(ctrl_r[2:0])) |=> (dev_reset_o || pc_sp_clear_o))
        else $error("overflow at selected period gave no reset");

    a_off_silent: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_r == WDTRC_ST_OFF) |-> (cnt_r == '0 && !tmo))
        else $error("disabled watchdog counted or timed out");

    a_illegal_rst: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        srst_fire |=> (ctrl_r == `WDTRC_CTRL_POR && st_r == WDTRC_ST_RUN && dev_reset_o))
        else $error("illegal code did not end in a device reset");

    a_wrf_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        srst_fire |=> wrf_r)
        else $error("soft reset flag not set");

    a_wrf_sw: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!wrf_r && !srst_fire) |=> !wrf_r)
        else $error("soft reset flag set by software");

    a_sleep_ovf: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (tmo && cpu_i.sleep) |=> (to_r && pdf_r && pc_sp_clear_o && !dev_reset_o))
        else $error("sleep time-out handled wrongly");

    a_count_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cpu_i.clear_watchdog_instruction || cpu_i.halt) |=> cnt_r == '0)
        else $error("clear event left count nonzero");

    a_flags_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (bus_i.rd && bus_i.addr == 3'h1) |=> (rdata_o[7:4] == 4'h0 && rdata_o[0] == $past(wrf_r)))
        else $error("flag register read wrong");
endmodule : wdtrc_top
`default_nettype wire

// *** tb/wdtrc_cpu_model.sv ***
// cpu core stand-in: low-speed tick source, clear and halt instructions, sleep level
`default_nettype none
module wdtrc_cpu_model (
    input wire logic clk_i, // system clock
    input wire logic arst_n_i, // async reset, active low
    output logic tick_o, // one low-speed tick every second cycle
    output var wdtrc_pkg::wdtrc_cpu_t cpu_o // instruction and mode events
);
    timeunit 1ns;
    timeprecision 1ps;
    import wdtrc_pkg::*;

    // ticks run free: the oscillator does not pause for clears or halts
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= ~tick_o;
        end
    end

    initial cpu_o = '0;

    // one-cycle instruction pulse, launched right after a rising edge
    task automatic pulse(input logic is_halt);
        @(posedge clk_i);
        cpu_o.clear_watchdog_instruction <= ~is_halt;
        cpu_o.halt <= is_halt;
        @(posedge clk_i);
        cpu_o.clear_watchdog_instruction <= 1'b0;
        cpu_o.halt <= 1'b0;
    endtask : pulse

    // sleep is a level held until the next call
    task automatic set_sleep(input logic lvl);
        @(posedge clk_i);
        cpu_o.sleep <= lvl;
    endtask : set_sleep
endmodule : wdtrc_cpu_model
`default_nettype wire

// *** tb/wdtrc_tb_top.sv ***
// self-checking bench for the watchdog reset controller
`default_nettype none
module wdtrc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wdtrc_pkg::*;

    // short soft reset delay keeps the run brief
    localparam int SRST = 4;
    logic clk_i;
    logic arst_n_i;
    wdtrc_req_t bus_i;
    wdtrc_cpu_t cpu;
    logic tick;
    logic [7:0] rdata_o, port_data_o, port_dir_o;
    logic dev_reset_o, pc_sp_clear_o, irq_o;
    int error_cnt = 0;
    int num_checks = 0;
    int tick_cnt = 0;
    int n;

    always #12.5 clk_i = ~clk_i;

    wdtrc_cpu_model u_wdtrc_cpu_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .tick_o(tick), .cpu_o(cpu));

    wdtrc_top #(.SRESET_CYC(SRST)) u_wdtrc_top (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .low_speed_rc_oscillator_tick_i(tick), .bus_i(bus_i), .cpu_i(cpu),
        .rdata_o(rdata_o), .dev_reset_o(dev_reset_o), .pc_sp_clear_o(pc_sp_clear_o),
        .port_data_o(port_data_o), .port_dir_o(port_dir_o), .irq_o(irq_o)
    );

    // ticks since the last clear or halt, kept apart from the design's count
    always @(posedge clk_i) begin
        if (cpu.clear_watchdog_instruction || cpu.halt) tick_cnt <= 0;
        else if (tick) tick_cnt <= tick_cnt + 1;
    end

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1;
        chk(rdata_o, exp);
    endtask : rd

    // bounded wait for a reset pulse; a missing required pulse ends the run
    task automatic wait_ev(input logic pc_side, input int lim, input logic must);
        n = 0;
        while (n < lim && (pc_side ? pc_sp_clear_o : dev_reset_o) !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (must && n >= lim) begin
            error_cnt++;
            $display("Error at %0t: waited %h cycles, expected fewer than %h", $time, n, lim);
            report_and_stop();
        end
    endtask : wait_ev

    initial begin
        clk_i = 1'b0;
        arst_n_i = 1'b0;
        bus_i = '0;
        repeat (12) @(posedge clk_i);
        chk(pc_sp_clear_o, 1'b1);
        chk(port_data_o, 8'hFF);
        chk(port_dir_o, 8'hFF);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk(pc_sp_clear_o, 1'b0);
        rd(3'h0, 8'h53);
        rd(3'h1, 8'h00);
        // shortest periods only; the long ones would dominate run time
        for (int s = 0; s < 3; s++) begin
            wr(3'h0, {5'h0A, s[2:0]});
            u_wdtrc_cpu_model.pulse(1'b0);
            wait_ev(1'b0, 20000, 1'b1);
            chk(tick_cnt, 32'd1 << (8 + 2 * s));
        end
        rd(3'h0, 8'h53);
        rd(3'h2, 8'h01);
        wr(3'h4, 8'h01);
        #1 chk(irq_o, 1'b1);
        wr(3'h4, 8'h00);
        #1 chk(irq_o, 1'b0);
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h01);
        #1 chk(irq_o, 1'b0);
        rd(3'h3, 8'h00);
        // clearing in time keeps the device out of reset
        wr(3'h0, 8'h50);
        repeat (3) begin
            u_wdtrc_cpu_model.pulse(1'b0);
            wait_ev(1'b0, 400, 1'b0);
            chk(n, 400);
        end
        wr(3'h0, 8'hA8);
        u_wdtrc_cpu_model.pulse(1'b1);
        wait_ev(1'b0, 1200, 1'b0);
        chk(n, 1200);
        wr(3'h0, 8'h50);
        u_wdtrc_cpu_model.set_sleep(1'b1);
        u_wdtrc_cpu_model.pulse(1'b1);
        wait_ev(1'b1, 1000, 1'b1);
        chk(dev_reset_o, 1'b0);
        chk(tick_cnt, 256);
        rd(3'h2, 8'h03);
        wr(3'h2, 8'h00);
        rd(3'h2, 8'h03);
        rd(3'h5, 8'h00);
        u_wdtrc_cpu_model.set_sleep(1'b0);
        wr(3'h5, 8'h03);
        wr(3'h0, 8'h07);
        wait_ev(1'b0, 100, 1'b1);
        chk(n, SRST);
        rd(3'h1, 8'h01);
        rd(3'h0, 8'h53);
        rd(3'h3, 8'h02);
        wr(3'h1, 8'h01);
        rd(3'h1, 8'h01);
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h00);
        wr(3'h6, 8'h5A);
        #1 chk(port_data_o, 8'h5A);
        wr(3'h7, 8'h0F);
        rd(3'h7, 8'h0F);
        // second power-on reset mid-run: written ports and flags must return to power-up values
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(pc_sp_clear_o, 1'b1);
        chk(port_data_o, 8'hFF);
        chk(port_dir_o, 8'hFF);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk(pc_sp_clear_o, 1'b0);
        rd(3'h0, 8'h53);
        rd(3'h2, 8'h00);
        report_and_stop();
    end
endmodule : wdtrc_tb_top
`default_nettype wire
